// ==== hw/builtin_io_port.sv ====
// Built-in I/O port: sixteen filtered inputs, eight selectable outputs,
// input image, pulse catch, lamps. AXI4-Lite slave for software.
// Assumes counter/positioning engines drive funcOut on the same clock.
// Notes on behaviour
// - Counter mode: pins 0,1 coincidence 1, pins 2,3 coincidence 2.
// - Positioning: pins 2,3 clear, 4,5 fwd/rev, 6,7 the same fwd/rev levels.
// - Pins unused by the chosen function act as general outputs.
// - Function-owned pins ignore program output image writes.
// - Function levels never copy back into the output image.
// - Output lamps show the actual pin level.
// - Filtered level copies into the input image except in pulse catch.
// - Pulse catch sets the image bit for exactly one scan.
// - Inputs not used by a function act as general inputs.
// - Input lamps show pin levels, untouched by image writes.
// - Pins 0-5 high-speed class, 6-15 standard class.
// - Input image updates at the end-of-scan instruction.
// - Direct-input view samples the filtered pin level at access.
// - Partial refresh copies just the named range into the image.
// - Standard filter: 0.1, 1, 5, 10, 20 or 70 ms.
// - High-speed filter: 0.01, 0.1, 0.2, 0.4, 0.6 or 1 ms.
// - Shortest standard filter off delay up to twice the setting.
// - Shortest high-speed filter response up to twice the setting.
`include "builtin_io_map.svh"
`timescale 1ns/1ps
`default_nettype none
module builtin_io_port
    import builtin_io_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] inPins,
    output logic      [7:0]  outPins,
    output logic      [15:0] inputStatusLamps,
    output logic      [7:0]  outputStatusLamps,
    input  wire logic [3:0]  funcOut,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // funcOut, counter: {coin2 ch2, coin2 ch1, coin1 ch2, coin1 ch1};
    // positioning: {axis2 fwd/rev, axis1 fwd/rev, axis2 clear, axis1 clear}
    logic [15:0] syncA, syncB;
    logic [15:0] filtered, next_filtered;
    logic [15:0] inputImage, next_inputImage;
    logic [15:0] catchEn, next_catchEn;
    logic [15:0] caughtPend, next_caughtPend;
    logic [7:0]  outputImage, next_outputImage;
    logic [7:0]  outReg, next_outReg;
    logic [7:0]  funcUse, next_funcUse;
    logic [7:0]  stagedUse, next_stagedUse;
    func_mode_t  mode, next_mode, stagedMode, next_stagedMode;
    logic [17:0] filtFast, next_filtFast;
    logic [29:0] filtStd, next_filtStd;
    logic [7:0]  ownedPins;
    logic [7:0]  funcLevel;
    logic [3:0]  funcOutReg;
    logic        endScan, refresh;
    logic [3:0]  rfsLo, rfsHi;

    // Pins come from outside: two flops before any logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA <= 16'h0000;
            syncB <= 16'h0000;
        end else begin
            syncA <= inPins;
            syncB <= syncA;
        end
    end

    // Per-pin debounce; class fixed by pin index
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_filt
            filt_cnt_t cnt, next_cnt;
            filt_cnt_t limit;
            filt_sel_t sel;
            always_comb begin
                if (gi < 6) begin
                    sel = filtFast[(gi < 6 ? gi : 0)*3 +: 3];
                    unique case (sel)
                        3'd0: limit = filt_cnt_t'(`CYC(`T_FAST_0_NS));
                        3'd1: limit = filt_cnt_t'(`CYC(`T_FAST_1_NS));
                        3'd2: limit = filt_cnt_t'(`CYC(`T_FAST_2_NS));
                        3'd3: limit = filt_cnt_t'(`CYC(`T_FAST_3_NS));
                        3'd4: limit = filt_cnt_t'(`CYC(`T_FAST_4_NS));
                        default: limit = filt_cnt_t'(`CYC(`T_FAST_5_NS));
                    endcase
                end else begin
                    sel = filtStd[(gi < 6 ? 0 : gi-6)*3 +: 3];
                    unique case (sel)
                        3'd0: limit = filt_cnt_t'(`CYC(`T_STD_0_NS));
                        3'd1: limit = filt_cnt_t'(`CYC(`T_STD_1_NS));
                        3'd2: limit = filt_cnt_t'(`CYC(`T_STD_2_NS));
                        3'd3: limit = filt_cnt_t'(`CYC(`T_STD_3_NS));
                        3'd4: limit = filt_cnt_t'(`CYC(`T_STD_4_NS));
                        default: limit = filt_cnt_t'(`CYC(`T_STD_5_NS));
                    endcase
                end
                // Restart whenever the input matches filtered; accept when stable long enough
                next_cnt = cnt;
                next_filtered[gi] = filtered[gi];
                if (syncB[gi] == filtered[gi]) begin
                    next_cnt = '0;
                end else if (cnt + filt_cnt_t'(1) >= limit) begin
                    next_cnt = '0;
                    next_filtered[gi] = syncB[gi];
                end else begin
                    next_cnt = cnt + filt_cnt_t'(1);
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cnt <= '0;
                end else begin
                    cnt <= next_cnt;
                end
            end
        end
    endgenerate

    // Input image, pulse catch and partial refresh
    always_comb begin
        next_inputImage = inputImage;
        next_caughtPend = caughtPend;
        for (int i = 0; i < 16; i++) begin
            // Rising edge is latched until the next scan end
            if (catchEn[i] && next_filtered[i] && !filtered[i])
                next_caughtPend[i] = 1'b1;
            if (endScan) begin
                if (catchEn[i]) begin
                    next_inputImage[i] = caughtPend[i];
                    next_caughtPend[i] = next_filtered[i] && !filtered[i];
                end else begin
                    next_inputImage[i] = filtered[i];
                end
            end else if (refresh && i >= rfsLo && i <= rfsHi
                         && !catchEn[i]) begin
                next_inputImage[i] = filtered[i];
            end
        end
    end

    // Output routing: ownership held in mode/funcUse
    always_comb begin
        ownedPins = 8'h00;
        funcLevel = 8'h00;
        unique case (mode)
            FUNC_COUNTER: begin
                ownedPins = {4'h0, funcUse[3:0]};
                funcLevel = {4'h0, funcOutReg};
            end
            FUNC_POSITION: begin
                ownedPins = {funcUse[7:2], 2'b00};
                funcLevel = {funcOutReg[3:2], funcOutReg[3:2],
                             funcOutReg[1:0], 2'b00};
            end
            default: begin
                ownedPins = 8'h00;
                funcLevel = 8'h00;
            end
        endcase
        for (int j = 0; j < 8; j++) begin
            // Program image only where no function owns the pin
            next_outReg[j] = ownedPins[j] ? funcLevel[j]
                                          : outputImage[j];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            funcOutReg <= 4'h0;
            outReg <= 8'h00;
            inputImage <= 16'h0000;
            caughtPend <= 16'h0000;
            filtered <= 16'h0000;
        end else begin
            funcOutReg <= funcOut;
            outReg <= next_outReg;
            inputImage <= next_inputImage;
            caughtPend <= next_caughtPend;
            filtered <= next_filtered;
        end
    end

    assign outPins = outReg;
    assign outputStatusLamps = outReg;
    assign inputStatusLamps = syncB;

    // AXI4-Lite write: take address and data in either order
    logic        awHeld, wHeld, next_awHeld, next_wHeld;
    logic [11:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic        bValid, next_bValid;
    logic [1:0]  bResp, next_bResp;
    logic        doWrite;
    assign s_axi_awready = !awHeld && !bValid;
    assign s_axi_wready  = !wHeld && !bValid;
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_bValid = bValid;
        next_bResp = bResp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
        end
        doWrite = awHeld && wHeld;
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bValid = 1'b1;
            unique case (awAddr)
                `REG_FUNC_SEL, `REG_FILT_FAST, `REG_FILT_STD,
                `REG_OUT_IMAGE, `REG_IN_IMAGE, `REG_SCAN_CTRL,
                `REG_CATCH_EN: next_bResp = 2'b00;
                default: next_bResp = 2'b10;
            endcase
        end
        if (bValid && s_axi_bready)
            next_bValid = 1'b0;
    end
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;

    // Register writes; scan strobes are one-cycle pulses
    always_comb begin
        next_stagedMode = stagedMode;
        next_stagedUse = stagedUse;
        next_mode = mode;
        next_funcUse = funcUse;
        next_filtFast = filtFast;
        next_filtStd = filtStd;
        next_outputImage = outputImage;
        next_catchEn = catchEn;
        endScan = 1'b0;
        refresh = 1'b0;
        rfsLo = wData[`SCAN_LO_LSB +: 4];
        rfsHi = wData[`SCAN_HI_LSB +: 4];
        if (doWrite) begin
            unique case (awAddr)
                `REG_FUNC_SEL: begin
                    // Staged copy is only read back; load bit switches pin ownership at once
                    next_stagedMode = func_mode_t'(wData[`FSEL_MODE_LSB +: 2]);
                    next_stagedUse = wData[`FSEL_USE_LSB +: 8];
                    if (wData[`FSEL_LOAD_BIT]) begin
                        next_mode = func_mode_t'(wData[`FSEL_MODE_LSB +: 2]);
                        next_funcUse = wData[`FSEL_USE_LSB +: 8];
                    end
                end
                `REG_FILT_FAST: next_filtFast = wData[17:0];
                `REG_FILT_STD:  next_filtStd = wData[29:0];
                `REG_OUT_IMAGE: next_outputImage = wData[7:0];
                `REG_CATCH_EN:  next_catchEn = wData[15:0];
                `REG_SCAN_CTRL: begin
                    endScan = wData[`SCAN_END_BIT];
                    refresh = wData[`SCAN_RFS_BIT];
                end
                default: next_catchEn = catchEn;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 12'h000;
            wData <= 32'h0000_0000;
            bValid <= 1'b0;
            bResp <= 2'b00;
            mode <= FUNC_GENERAL;
            stagedMode <= FUNC_GENERAL;
            funcUse <= 8'h00;
            stagedUse <= 8'h00;
            filtFast <= 18'h0_0000;
            filtStd <= 30'h0000_0000;
            outputImage <= 8'h00;
            catchEn <= 16'h0000;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            bValid <= next_bValid;
            bResp <= next_bResp;
            mode <= next_mode;
            stagedMode <= next_stagedMode;
            funcUse <= next_funcUse;
            stagedUse <= next_stagedUse;
            filtFast <= next_filtFast;
            filtStd <= next_filtStd;
            outputImage <= next_outputImage;
            catchEn <= next_catchEn;
        end
    end

    // AXI4-Lite read: one cycle after the address is taken
    logic        rValid, next_rValid;
    logic [31:0] rData, next_rData;
    logic [1:0]  rResp, next_rResp;
    assign s_axi_arready = !rValid;
    always_comb begin
        next_rValid = rValid;
        next_rData = rData;
        next_rResp = rResp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rValid = 1'b1;
            next_rResp = 2'b00;
            unique case (s_axi_araddr[11:0])
                `REG_FUNC_SEL:  next_rData = {22'h0, funcUse, mode};
                `REG_FILT_FAST: next_rData = {14'h0, filtFast};
                `REG_FILT_STD:  next_rData = {2'h0, filtStd};
                `REG_OUT_IMAGE: next_rData = {24'h0, outputImage};
                `REG_IN_IMAGE:  next_rData = {16'h0, inputImage};
                `REG_DIRECT_IN: next_rData = {16'h0, filtered};
                `REG_SCAN_CTRL: next_rData = 32'h0000_0000;
                `REG_LAMPS:     next_rData = {8'h0, outReg, syncB};
                `REG_CATCH_EN:  next_rData = {16'h0, catchEn};
                `REG_FUNC_OUT:  next_rData = {22'h0, stagedUse, stagedMode};
                default: begin
                    next_rData = 32'h0000_0000;
                    next_rResp = 2'b10;
                end
            endcase
        end else if (rValid && s_axi_rready) begin
            next_rValid = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rValid <= 1'b0;
            rData <= 32'h0000_0000;
            rResp <= 2'b00;
        end else begin
            rValid <= next_rValid;
            rData <= next_rData;
            rResp <= next_rResp;
        end
    end
    assign s_axi_rvalid = rValid;
    assign s_axi_rdata = rData;
    assign s_axi_rresp = rResp;
endmodule
`default_nettype wire

// ==== hw/builtin_io_map.svh ====
// Offsets, field positions, reset values and timing counts for the
// built-in I/O port. Assumes a 25 MHz system clock.
`ifndef BUILTIN_IO_MAP_SVH
`define BUILTIN_IO_MAP_SVH

// Register byte addresses
`define REG_FUNC_SEL      12'h000
`define REG_FILT_FAST     12'h004
`define REG_FILT_STD      12'h008
`define REG_OUT_IMAGE     12'h00C
`define REG_IN_IMAGE      12'h010
`define REG_DIRECT_IN     12'h014
`define REG_SCAN_CTRL     12'h018
`define REG_LAMPS         12'h01C
`define REG_CATCH_EN      12'h020
`define REG_FUNC_OUT      12'h024

// Field positions
`define FSEL_MODE_LSB     0
`define FSEL_USE_LSB      2
`define FSEL_LOAD_BIT     16
`define SCAN_END_BIT      0
`define SCAN_RFS_BIT      1
`define SCAN_LO_LSB       8
`define SCAN_HI_LSB       16

// Reset values
`define FSEL_RESET        2'h0
`define FILT_RESET        32'h0000_0000

// Filter times in nanoseconds, then cycles at 40 ns
`define CLK_NS            40
`define T_FAST_0_NS       10000
`define T_FAST_1_NS       100000
`define T_FAST_2_NS       200000
`define T_FAST_3_NS       400000
`define T_FAST_4_NS       600000
`define T_FAST_5_NS       1000000
`define T_STD_0_NS        100000
`define T_STD_1_NS        1000000
`define T_STD_2_NS        5000000
`define T_STD_3_NS        10000000
`define T_STD_4_NS        20000000
`define T_STD_5_NS        70000000
`define CYC(t)            (((t) + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== hw/builtin_io_pkg.sv ====
// Types shared by the built-in I/O port.
// Assumes builtin_io_map.svh supplies all numbers.
package builtin_io_pkg;
    typedef enum logic [1:0] {
        FUNC_GENERAL = 2'b00,
        FUNC_COUNTER = 2'b01,
        FUNC_POSITION = 2'b11
    } func_mode_t;
    typedef logic [2:0] filt_sel_t;
    typedef logic [21:0] filt_cnt_t;
endpackage

// ==== dv/io_port_monitor.sv ====
// Checker for the built-in I/O port: pins, lamps and bus answers.
// Assumes it is bound to builtin_io_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module io_port_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] inPins,
    input wire logic [7:0]  outPins,
    input wire logic [15:0] inputStatusLamps,
    input wire logic [7:0]  outputStatusLamps,
    input wire logic [3:0]  funcOut,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic [3:0] lastFunc;
    logic       touch;

    // Any write or engine change restarts the quiet count
    assign touch = (s_axi_awvalid && s_axi_awready)
                || (s_axi_wvalid && s_axi_wready) || (funcOut != lastFunc);

    // Saturating, so a long idle never wraps to zero
    always_comb begin
        if (!rst_n || touch) begin
            next_quiet = 4'h0;
        end else if (quiet != 4'hF) begin
            next_quiet = quiet + 4'h1;
        end else begin
            next_quiet = quiet;
        end
    end

    // Helper registers
    always_ff @(posedge clk) begin
        quiet    <= next_quiet;
        lastFunc <= funcOut;
    end

    sequence wTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_out_lamp_match: assert property (
        outputStatusLamps == outPins)
        else $error("output lamps differ from pins");
    a_in_lamp_follow: assert property (
        $stable(inPins) [*6] |-> inputStatusLamps == inPins)
        else $error("input lamps do not follow pins");
    a_pins_hold_idle: assert property (
        quiet >= 4'h6 |-> $stable(outPins))
        else $error("output pins moved without a cause");
    a_write_answer: assert property (
        wTaken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after take");
    a_read_answer: assert property (rTaken |=> s_axi_rvalid)
        else $error("read answer missing");
    a_bvalid_drop: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_rvalid_drop: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_read_gate: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready while answering");
    a_bresp_code: assert property (
        s_axi_bvalid |-> (s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10))
        else $error("illegal write response");
endmodule

bind builtin_io_port io_port_monitor MON (
    .clk(clk), .rst_n(rst_n), .inPins(inPins), .outPins(outPins),
    .inputStatusLamps(inputStatusLamps), .funcOut(funcOut),
    .outputStatusLamps(outputStatusLamps),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ==== dv/field_io_model.sv ====
// Field side: switches and sensors on the inputs, engines on funcOut.
// Assumes the bench calls drive() and shares the port clock.
`timescale 1ns/1ps
`default_nettype none
module field_io_model (
    input  wire logic        clk,
    output logic      [15:0] inPins,
    output logic      [3:0]  funcOut
);
    // Quiet field at time zero
    initial begin
        inPins  = 16'h0000;
        funcOut = 4'h0;
    end

    // Levels change just after a rising edge
    task automatic drive(input logic [15:0] p, input logic [3:0] f);
        @(posedge clk);
        inPins  <= p;
        funcOut <= f;
    endtask
endmodule
`default_nettype wire

// ==== dv/builtin_io_pin_function_select_test.sv ====
// Bench for the built-in I/O port: AXI4-Lite calls with expectations.
// Assumes default filter codes after reset and a 40 ns clock.
`include "builtin_io_map.svh"
`timescale 1ns/1ps
`default_nettype none
module builtin_io_pin_function_select_test import builtin_io_pkg::*;;
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic [31:0] awAddr  = 32'h0000_0000;
    logic [31:0] wData   = 32'h0000_0000;
    logic [31:0] arAddr  = 32'h0000_0000;
    logic        awValid = 1'b0;
    logic        wValid  = 1'b0;
    logic        bReady  = 1'b0;
    logic        arValid = 1'b0;
    logic        rReady  = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [1:0]  bResp, rResp, resp;
    logic [31:0] rData, rdv;
    logic [7:0]  outPins, outLamps;
    logic [15:0] inPins, inLamps;
    logic [3:0]  funcOut;
    int          failures    = 0;
    int          checks_done = 0;

    // Free-running clock
    always #20 clk = ~clk;

    builtin_io_port DUT (
        .clk(clk), .rst_n(rst_n), .inPins(inPins), .outPins(outPins),
        .inputStatusLamps(inLamps), .outputStatusLamps(outLamps),
        .funcOut(funcOut), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady));
    field_io_model FIELD (.clk(clk), .inPins(inPins), .funcOut(funcOut));

    function automatic logic [31:0] fsel(func_mode_t m, logic [7:0] u,
                                         logic ld);
        return {15'h0000, ld, 6'h00, u, m};
    endfunction

    // Comparison and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Bus cycles; each channel is released only at its own handshake
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (!awDone && awReady === 1'b1) begin
                awDone = 1'b1;
                awValid <= 1'b0;
            end
            if (!wDone && wReady === 1'b1) begin
                wDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        while (bValid !== 1'b1) @(posedge clk);
        resp = bResp;
        bReady <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clk); while (arReady !== 1'b1);
        arValid <= 1'b0;
        while (rValid !== 1'b1) @(posedge clk);
        rdv = rData;
        resp = rResp;
        rReady <= 1'b0;
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        check(rdv, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Hang guard, well beyond the roughly 14.5k cycles of the tests
    initial begin
        idle(60000);
        failures++;
        finish_test();
    end

    // Main sequence
    initial begin
        idle(16);
        rst_n <= 1'b1;
        rdChk(`REG_FILT_FAST, `FILT_RESET);
        rdChk(`REG_FILT_STD, `FILT_RESET);
        rd(32'h0000_0040);
        check(32'(resp), 32'h0000_0002);
        check(rdv, 32'h0000_0000);
        wr(32'h0000_0040, 32'h0000_00FF);
        check(32'(resp), 32'h0000_0002);
        wr(`REG_OUT_IMAGE, 32'h0000_00A5);
        check(32'(resp), 32'h0000_0000);
        idle(3);
        check(32'(outPins), 32'h0000_00A5);
        check(32'(outLamps), 32'h0000_00A5);
        FIELD.drive(16'h0000, 4'b1010);
        wr(`REG_FUNC_SEL, fsel(FUNC_COUNTER, 8'h0F, 1'b0));
        idle(3);
        check(32'(outPins), 32'h0000_00A5);
        rdChk(`REG_FUNC_OUT, 32'h0000_003D);
        rdChk(`REG_FUNC_SEL, 32'h0000_0000);
        wr(`REG_FUNC_SEL, fsel(FUNC_COUNTER, 8'h0F, 1'b1));
        idle(3);
        check(32'(outPins), 32'h0000_00AA);
        rdChk(`REG_FUNC_SEL, 32'h0000_003D);
        wr(`REG_OUT_IMAGE, 32'h0000_0000);
        idle(3);
        check(32'(outPins), 32'h0000_000A);
        check(32'(outLamps), 32'h0000_000A);
        rdChk(`REG_OUT_IMAGE, 32'h0000_0000);
        wr(`REG_OUT_IMAGE, 32'h0000_0003);
        FIELD.drive(16'h0000, 4'b0101);
        wr(`REG_FUNC_SEL, fsel(FUNC_POSITION, 8'hFC, 1'b1));
        idle(3);
        check(32'(outPins), 32'h0000_0057);
        FIELD.drive(16'h0000, 4'b1010);
        idle(3);
        check(32'(outPins), 32'h0000_00AB);
        wr(`REG_FUNC_SEL, fsel(FUNC_COUNTER, 8'h03, 1'b1));
        idle(3);
        check(32'(outPins), 32'h0000_0002);
        wr(`REG_FUNC_SEL, fsel(FUNC_GENERAL, 8'h00, 1'b1));
        idle(3);
        check(32'(outPins), 32'h0000_0003);
        // Fast pin settles long before the standard one
        FIELD.drive(16'h8041, 4'h0);
        idle(1000);
        check(32'(inLamps), 32'h0000_8041);
        rdChk(`REG_DIRECT_IN, 32'h0000_0001);
        idle(5500);
        rdChk(`REG_DIRECT_IN, 32'h0000_8041);
        rdChk(`REG_IN_IMAGE, 32'h0000_0000);
        wr(`REG_SCAN_CTRL, 32'h0000_0002);
        rdChk(`REG_IN_IMAGE, 32'h0000_0001);
        wr(`REG_SCAN_CTRL, 32'h0000_0001);
        rdChk(`REG_IN_IMAGE, 32'h0000_8041);
        wr(`REG_IN_IMAGE, 32'h0000_0000);
        check(32'(inLamps), 32'h0000_8041);
        rdChk(`REG_LAMPS, 32'h0003_8041);
        // Short glitch must not pass the filter
        FIELD.drive(16'h8043, 4'h0);
        idle(100);
        FIELD.drive(16'h8041, 4'h0);
        idle(400);
        rdChk(`REG_DIRECT_IN, 32'h0000_8041);
        wr(`REG_FILT_FAST, 32'h0000_0001);
        FIELD.drive(16'h8040, 4'h0);
        idle(1000);
        rdChk(`REG_DIRECT_IN, 32'h0000_8041);
        idle(5000);
        rdChk(`REG_DIRECT_IN, 32'h0000_8040);
        // Pulse caught on pin 2, gone again after one scan
        wr(`REG_CATCH_EN, 32'h0000_0004);
        rdChk(`REG_CATCH_EN, 32'h0000_0004);
        FIELD.drive(16'h8044, 4'h0);
        idle(600);
        FIELD.drive(16'h8040, 4'h0);
        idle(600);
        wr(`REG_SCAN_CTRL, 32'h0000_0001);
        rdChk(`REG_IN_IMAGE, 32'h0000_8044);
        wr(`REG_SCAN_CTRL, 32'h0000_0001);
        rdChk(`REG_IN_IMAGE, 32'h0000_8040);
        finish_test();
    end
endmodule
`default_nettype wire
